// *** dv/adc_pixel_model.sv ***
// Stand-in for the converter and the downstream pixel processor.
// Assumes pixelValid pulses once per forwarded sample.
`timescale 1ns/1ps

module adc_pixel_model (
    input wire logic clk,
    input wire logic pixelValid,
    input wire logic [11:0] pixelData,
    output logic [11:0] adcData,
    output int misCnt,
    output int okCnt
);
    initial adcData = 12'h5a3;

    // new level only after a sample is taken, so each conversion
    // window sees one stable value
    always @(posedge clk) begin
        if (pixelValid === 1'b1) begin
            if (pixelData !== adcData) begin
                misCnt++;
            end else begin
                okCnt++;
            end
            adcData <= #1 adcData + 12'h3b7;
        end
    end
endmodule : adc_pixel_model

// *** dv/ccd_exposure_clock_sequencer_bench.sv ***
// Self-checking bench: normal, short and clear-only runs, pulse counts.
// Assumes the bound checker and the converter model beside the block.
`timescale 1ns/1ps

module ccd_exposure_clock_sequencer_bench;
    import ccd_seq_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic runStart = 1'b0;
    logic runStop = 1'b0;
    logic [23:0] exposureUs = 24'h0;
    logic [9:0] startRow = 10'h0;
    logic [9:0] endRow = 10'h0;
    readout_mode_t readoutMode = MODE_FULL;
    logic [7:0] overclockCount = 8'h0;
    logic [11:0] adcData, pixelData;
    logic imageRowClk, storeRowClk, serialClk, convStart, pixelValid;
    logic pixelOverclock, frameStart, busy, shortMode, timingFault;
    int errors, total_checks, cyc, misCnt, okCnt;
    int nImg, nSto, nSer, nPv, nOv, nFs, lastImg, firstImg;
    int fImg, fSto, fSer, fPv, fOv, fLastImg;

    ccd_exposure_clock_sequencer u_ccd_exposure_clock_sequencer (
        .clk(clk), .srst(srst), .runStart(runStart), .runStop(runStop),
        .exposureUs(exposureUs), .startRow(startRow), .endRow(endRow),
        .readoutMode(readoutMode), .overclockCount(overclockCount),
        .adcData(adcData), .imageRowClk(imageRowClk),
        .storeRowClk(storeRowClk), .serialClk(serialClk),
        .convStart(convStart), .pixelData(pixelData),
        .pixelValid(pixelValid), .pixelOverclock(pixelOverclock),
        .frameStart(frameStart), .busy(busy), .shortMode(shortMode),
        .timingFault(timingFault)
    );
    adc_pixel_model u_adc_pixel_model (
        .clk(clk), .pixelValid(pixelValid), .pixelData(pixelData),
        .adcData(adcData), .misCnt(misCnt), .okCnt(okCnt)
    );

    always #50 clk = ~clk;

    // --------------------------------------------------------------
    // pulse counters, snapshot at every frame start
    // --------------------------------------------------------------
    always @(posedge clk) begin
        cyc++;
        if (cyc == 100000) begin
            errors++;
            report_and_stop();
        end
        if (imageRowClk === 1'b1) begin
            if (nImg == fImg) firstImg = cyc;
            nImg++;
            lastImg = cyc;
        end
        if (storeRowClk === 1'b1) nSto++;
        if (serialClk === 1'b1) nSer++;
        if (pixelValid === 1'b1) nPv++;
        if (pixelValid === 1'b1 && pixelOverclock === 1'b1) nOv++;
        if (frameStart === 1'b1) begin
            nFs++;
            fImg = nImg;
            fSto = nSto;
            fSer = nSer;
            fPv = nPv;
            fOv = nOv;
            fLastImg = lastImg;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // settings stay put for the whole run
    task automatic start_run(input readout_mode_t m, input logic [7:0] o,
            input logic [9:0] s, input logic [9:0] e, input logic [23:0] us);
        @(posedge clk);
        #1;
        readoutMode = m;
        overclockCount = o;
        startRow = s;
        endRow = e;
        exposureUs = us;
        runStart = 1'b1;
        @(posedge clk);
        #1;
        runStart = 1'b0;
    endtask : start_run

    task automatic stop_run;
        @(posedge clk);
        #1;
        runStop = 1'b1;
        wait (busy === 1'b0);
        repeat (6) @(posedge clk);
        #1;
        runStop = 1'b0;
    endtask : stop_run

    // 2 rows of 260+2, exposure long enough for overlap
    task automatic test_normal;
        int t0, i0, s0, p0, o0;
        start_run(MODE_FULL, 8'h02, 10'h003, 10'h004, 24'd500);
        wait (nFs >= 1);
        check(fImg, 2052);
        check(fSto, 2052 + 5);
        check(fSer, 2 * 262);
        check(fPv, 0);
        check(shortMode, 1'b0);
        t0 = fLastImg;
        i0 = fImg;
        s0 = fSto;
        p0 = fPv;
        o0 = fOv;
        wait (nFs >= 2);
        check(fImg - i0, 1026);
        check(fSto - s0, 2 + 1026 + 5);
        check(fPv - p0, 2 * 262);
        check(fOv - o0, 4);
        check(firstImg - t0 >= 5000 && firstImg - t0 <= 5012, 1);
        p0 = fPv;
        i0 = fImg;
        stop_run();
        check(nPv - p0, 2 * 262);
        check(nImg - i0, 0);
        check(timingFault, 1'b0);
    endtask : test_normal

    // stop lands at exposure entry, leaving just the clear step
    task automatic test_clear;
        int i0, s0;
        for (int k = 0; k < 4; k++) begin
            i0 = nImg;
            s0 = nSer;
            start_run(readout_mode_t'(k), 8'h01, 10'h0, 10'h0, 24'd10);
            stop_run();
            check(nImg - i0, 1026);
            check(nSer - s0, (k < 2 ? 260 : 520) + 1);
        end
    endtask : test_clear

    task automatic test_short;
        int n0, s0, i0, p0, o0;
        n0 = nFs;
        s0 = nSer;
        start_run(MODE_TWO_NODE_READOUT_FIRST_PAIR, 8'h01, 10'h002, 10'h002,
            24'd10);
        wait (nFs >= n0 + 1);
        check(shortMode, 1'b1);
        check(fSer - s0, 2 * 521);
        i0 = fImg;
        p0 = fPv;
        o0 = fOv;
        wait (nFs >= n0 + 2);
        check(fImg - i0, 2052);
        check(fPv - p0, 521);
        check(fOv - o0, 1);
        stop_run();
    endtask : test_short

    initial begin
        repeat (3) @(posedge clk);
        #1;
        srst = 1'b0;
        test_normal();
        test_clear();
        test_short();
        check(misCnt, 0);
        check(okCnt, nPv);
        report_and_stop();
    end
endmodule : ccd_exposure_clock_sequencer_bench

// *** dv/ccd_seq_chk.sv ***
// Concurrent checks on the sequencer's top ports.
// Assumes one clock domain; bound to every sequencer instance below.
`timescale 1ns/1ps

module ccd_seq_chk #(
    parameter int PIX_DIV = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic runStart,
    input wire logic runStop,
    input wire logic imageRowClk,
    input wire logic storeRowClk,
    input wire logic serialClk,
    input wire logic convStart,
    input wire logic pixelValid,
    input wire logic frameStart,
    input wire logic busy,
    input wire logic timingFault
);
    logic [7:0] gap_r;

    // saturating, so a long idle never wraps into a short gap
    always_ff @(posedge clk) begin
        if (srst || serialClk) begin
            gap_r <= srst ? 8'hff : 8'h01;
        end else if (gap_r != 8'hff) begin
            gap_r <= gap_r + 8'h01;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence s_sample;
        ##3 pixelValid;
    endsequence

    sequence s_take;
        runStart && !busy && !runStop;
    endsequence

    a_sample_follows: assert property (convStart |-> s_sample)
        else $error("sample missing after conversion");
    a_sample_cause: assert property (
        pixelValid |-> $past(convStart, 3))
        else $error("sample without conversion");
    a_conv_on_shift: assert property (convStart |-> serialClk)
        else $error("conversion without shift");
    a_shift_spacing: assert property (serialClk |-> gap_r >= PIX_DIV)
        else $error("shifts too close");
    a_steps_apart: assert property (
        (imageRowClk || storeRowClk) |-> !serialClk)
        else $error("row and shift clocks together");
    a_idle_quiet: assert property (
        !busy |-> !(imageRowClk || storeRowClk || serialClk || frameStart))
        else $error("clocking while idle");
    a_start_taken: assert property (
        s_take |=> busy && !timingFault)
        else $error("run start not taken");
    a_reset_clears: assert property (
        disable iff (1'b0) srst |=> !busy && !pixelValid)
        else $error("outputs active after reset");
endmodule : ccd_seq_chk

bind ccd_exposure_clock_sequencer ccd_seq_chk #(.PIX_DIV(PIX_DIV)) u_chk (
    .clk(clk), .srst(srst), .runStart(runStart), .runStop(runStop),
    .imageRowClk(imageRowClk), .storeRowClk(storeRowClk),
    .serialClk(serialClk), .convStart(convStart), .pixelValid(pixelValid),
    .frameStart(frameStart), .busy(busy), .timingFault(timingFault)
);

// *** hdl/ccd_exposure_clock_sequencer.sv ***
// Row and pixel clock sequencer for a frame-transfer sensor in timed
// exposure: clear, expose, transfer, position, discard, read, loop.
// Assumes an external ADC whose result settles within one clock cycle
// of convStart, and a controller that holds settings for the whole run.
`timescale 1ns/1ps
`include "ccd_seq_params.svh"

module ccd_exposure_clock_sequencer #(
    parameter int ROW_DIV = `ROW_DIV,
    parameter int PIX_DIV = `PIX_DIV,
    parameter int CLEAR_PASSES = `CLEAR_PASSES,
    parameter int XFER_MAX_CYC = `XFER_MAX_CYC,
    parameter int READ_MAX_CYC = `READ_MAX_CYC
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic runStart,
    input wire logic runStop,
    input wire logic [23:0] exposureUs,
    input wire logic [9:0] startRow,
    input wire logic [9:0] endRow,
    input wire ccd_seq_pkg::readout_mode_t readoutMode,
    input wire logic [7:0] overclockCount,
    input wire logic [`PIX_W-1:0] adcData,
    output logic imageRowClk,
    output logic storeRowClk,
    output logic serialClk,
    output logic convStart,
    output logic [`PIX_W-1:0] pixelData,
    output logic pixelValid,
    output logic pixelOverclock,
    output logic frameStart,
    output logic busy,
    output logic shortMode,
    output logic timingFault
);
    import ccd_seq_pkg::*;

    // ----------------------------------------------------------------------
    // derived constants
    // ----------------------------------------------------------------------
    localparam int D = `SAMPLE_DELAY;
    localparam logic [10:0] CLEAR_LAST = 11'(`CLEAR_ROWS - 1);
    localparam logic [10:0] XFER_LAST = 11'(`XFER_ROWS - 1);
    localparam logic [10:0] FLUSH_LAST = 11'(`FLUSH_ROWS - 1);
    localparam logic [10:0] POS_ADD = 11'(`POS_EXTRA_ROWS - 1);
    localparam logic [9:0] QUAD_LEN = 10'(`QUAD_PIX);
    localparam logic [9:0] PAIR_LEN = 10'(`PAIR_PIX);
    localparam logic [3:0] PASS_LAST = 4'(CLEAR_PASSES - 1);
    localparam logic [26:0] XFER_LIMIT = 27'(XFER_MAX_CYC);
    localparam logic [26:0] READ_LIMIT = 27'(READ_MAX_CYC);
    localparam logic [3:0] CYC_PER_US = 4'(`CLK_MHZ);
    localparam logic [31:0] PIX_DIV_W = 32'(PIX_DIV);
    localparam logic [31:0] ROW_DIV_W = 32'(ROW_DIV);

    seq_reg_t q;
    seq_reg_t n;
    logic rowTick;
    logic pixTick;
    logic running;

    assign running = (q.state != ST_IDLE);

    // ----------------------------------------------------------------------
    // rate enables
    // ----------------------------------------------------------------------
    rate_divider #(
        .DIV(ROW_DIV)
    ) rowRate (
        .clk(clk),
        .srst(srst),
        .run(running),
        .tick(rowTick)
    );

    rate_divider #(
        .DIV(PIX_DIV)
    ) pixRate (
        .clk(clk),
        .srst(srst),
        .run(running),
        .tick(pixTick)
    );

    // ----------------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------------
    // shifts in one register pass, counted down to zero
    function automatic logic [9:0] passLast(
        input readout_mode_t m,
        input logic [7:0] o
    );
        logic [9:0] base;
        base = QUAD_LEN;
        if (m == MODE_TWO_NODE_READOUT_FIRST_PAIR ||
            m == MODE_TWO_NODE_READOUT_SECOND_PAIR) begin
            base = PAIR_LEN;
        end
        passLast = base + {2'h0, o} - 10'h001;
    endfunction : passLast

    logic [10:0] rowsWanted;
    logic [9:0] rowLen;
    logic [31:0] readEst;
    logic [27:0] expReq;

    // estimate of store-to-processor time for the requested subarray
    always_comb begin
        rowsWanted = 11'({1'b0, endRow} - {1'b0, startRow}) + 11'h001;
        rowLen = passLast(readoutMode, overclockCount) + 10'h001;
        readEst = 32'(rowsWanted) * 32'(rowLen) * PIX_DIV_W
            + 32'(rowsWanted) * ROW_DIV_W;
        expReq = 28'(exposureUs) * 28'(CYC_PER_US);
    end

    // ----------------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------------
    always_comb begin
        n = q;
        n.imageRowClk = 1'b0;
        n.storeRowClk = 1'b0;
        n.serialClk = 1'b0;
        n.convStart = 1'b0;
        n.pixelValid = 1'b0;
        n.frameStart = 1'b0;

        // adc bus is settled well before its capture, so per-bit sync is safe
        n.adcMeta = adcData;
        n.adcSync = q.adcMeta;
        n.tagPipe = {q.tagPipe[D-2:0], 1'b0};
        n.ovPipe = {q.ovPipe[D-2:0], 1'b0};
        if (q.tagPipe[D-1]) begin
            n.pixelData = q.adcSync;
            n.pixelValid = 1'b1;
            n.pixelOverclock = q.ovPipe[D-1];
        end

        // exposure timer runs in every step so readout can hide it
        if (q.expCnt != 28'h0000000) begin
            n.expCnt = q.expCnt - 28'h0000001;
        end
        if (q.stepCyc != 27'h7ffffff) begin
            n.stepCyc = q.stepCyc + 27'h0000001;
        end
        if (runStop) begin
            n.stopReq = 1'b1;
        end

        case (q.state)
            ST_IDLE: begin
                if (runStart && !runStop) begin
                    n.startRow = startRow;
                    n.endRow = endRow;
                    n.mode = readoutMode;
                    n.ovc = overclockCount;
                    n.expCyc = expReq;
                    n.shortMode = (32'(expReq) < readEst);
                    n.stopReq = 1'b0;
                    n.timingFault = 1'b0;
                    n.rowCnt = CLEAR_LAST;
                    n.state = ST_CLEAR_ROWS;
                end
            end
            ST_CLEAR_ROWS: begin
                if (rowTick) begin
                    n.imageRowClk = 1'b1;
                    n.storeRowClk = 1'b1;
                    if (q.rowCnt == 11'h000) begin
                        n.expCnt = q.expCyc;
                        n.pixCnt = passLast(q.mode, q.ovc);
                        n.passCnt = PASS_LAST;
                        n.state = ST_CLEAR_SHIFT;
                    end else begin
                        n.rowCnt = q.rowCnt - 11'h001;
                    end
                end
            end
            ST_CLEAR_SHIFT: begin
                if (pixTick) begin
                    n.serialClk = 1'b1;
                    if (q.pixCnt != 10'h000) begin
                        n.pixCnt = q.pixCnt - 10'h001;
                    end else if (q.passCnt != 4'h0) begin
                        n.passCnt = q.passCnt - 4'h1;
                        n.pixCnt = passLast(q.mode, q.ovc);
                    end else begin
                        n.state = ST_EXPOSE;
                    end
                end
            end
            ST_EXPOSE: begin
                // stop is honoured only between frames
                if (q.stopReq) begin
                    n.state = ST_IDLE;
                end else if (q.expCnt == 28'h0000000) begin
                    n.rowCnt = XFER_LAST;
                    n.stepCyc = 27'h0000000;
                    n.state = ST_XFER;
                end
            end
            ST_XFER: begin
                if (rowTick) begin
                    n.imageRowClk = 1'b1;
                    n.storeRowClk = 1'b1;
                    if (q.rowCnt == 11'h000) begin
                        n.expCnt = q.expCyc;
                        n.rowCnt = 11'({1'b0, q.startRow}) + POS_ADD;
                        n.state = ST_POSITION;
                    end else begin
                        n.rowCnt = q.rowCnt - 11'h001;
                    end
                end
                if (q.stepCyc >= XFER_LIMIT) begin
                    n.timingFault = 1'b1;
                end
            end
            ST_POSITION: begin
                if (rowTick) begin
                    n.storeRowClk = 1'b1;
                    if (q.rowCnt == 11'h000) begin
                        n.pixCnt = passLast(q.mode, q.ovc);
                        n.state = ST_DISCARD;
                    end else begin
                        n.rowCnt = q.rowCnt - 11'h001;
                    end
                end
            end
            ST_DISCARD: begin
                if (pixTick) begin
                    n.serialClk = 1'b1;
                    if (q.pixCnt == 10'h000) begin
                        n.rowCnt = 11'({1'b0, q.endRow} - {1'b0, q.startRow});
                        n.stepCyc = 27'h0000000;
                        n.frameStart = 1'b1;
                        n.state = ST_READ_ROW;
                    end else begin
                        n.pixCnt = q.pixCnt - 10'h001;
                    end
                end
            end
            ST_READ_ROW: begin
                if (rowTick) begin
                    n.storeRowClk = 1'b1;
                    n.pixCnt = passLast(q.mode, q.ovc);
                    n.state = ST_READ_PIX;
                end
            end
            ST_READ_PIX: begin
                if (pixTick) begin
                    n.serialClk = 1'b1;
                    n.convStart = 1'b1;
                    n.tagPipe[0] = 1'b1;
                    // the last ovc shifts of each row are the overclocks
                    n.ovPipe[0] = (q.pixCnt < {2'h0, q.ovc});
                    if (q.pixCnt != 10'h000) begin
                        n.pixCnt = q.pixCnt - 10'h001;
                    end else if (q.rowCnt != 11'h000) begin
                        n.rowCnt = q.rowCnt - 11'h001;
                        n.state = ST_READ_ROW;
                    end else if (q.stopReq) begin
                        n.state = ST_IDLE;
                    end else if (q.shortMode) begin
                        n.rowCnt = FLUSH_LAST;
                        n.state = ST_FLUSH;
                    end else begin
                        n.state = ST_EXPOSE;
                    end
                end
                if (q.stepCyc >= READ_LIMIT) begin
                    n.timingFault = 1'b1;
                end
            end
            ST_FLUSH: begin
                if (rowTick) begin
                    n.imageRowClk = 1'b1;
                    if (q.rowCnt == 11'h000) begin
                        n.expCnt = q.expCyc;
                        n.state = ST_EXPOSE;
                    end else begin
                        n.rowCnt = q.rowCnt - 11'h001;
                    end
                end
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase

        // held one extra cycle so the last shift of a run is still covered
        n.busy = (n.state != ST_IDLE) || running;
    end

    // ----------------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
            q.state <= ST_IDLE;
            q.mode <= MODE_FULL;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------------------------------------
    // outputs, all straight from the state register
    // ----------------------------------------------------------------------
    assign imageRowClk = q.imageRowClk;
    assign storeRowClk = q.storeRowClk;
    assign serialClk = q.serialClk;
    assign convStart = q.convStart;
    assign pixelData = q.pixelData;
    assign pixelValid = q.pixelValid;
    assign pixelOverclock = q.pixelOverclock;
    assign frameStart = q.frameStart;
    assign busy = q.busy;
    assign shortMode = q.shortMode;
    assign timingFault = q.timingFault;

endmodule : ccd_exposure_clock_sequencer

// *** hdl/ccd_seq_params.svh ***
// Constants for the frame-transfer exposure clock sequencer: step counts,
// shift lengths, timing limits and default rates.
// Assumes a single 10 MHz clock; every count is in clock cycles unless named.
//
// Overview of operation
// - Clear: clock image and store rows 1026 times, then shift out registers.
// - One output-register pass is 256+4 pixels, or 512+8 in two-node modes.
// - Every discard pass adds the configured overclock shifts, all discarded.
// - Exposure timing starts at the last image row clocked into the store.
// - Normal mode: first exposure plain wait, later ones overlap readout.
// - Transfer clocks 1026 rows image-to-store and store-to-register together.
// - Image transfer completes within 60 ms; faster is only a goal.
// - Positioning clocks start row plus 2 store rows into the register.
// - After positioning, shift the register out and discard every sample.
// - Readout moves end minus start plus 1 rows, each then shifted out.
// - Each readout pixel is sampled, 12-bit digitised and forwarded.
// - Each readout row is followed by overclock shifts, sampled and forwarded.
// - Whole framestore readout takes no longer than 6.5 seconds.
// - Normal mode loops back to exposure after readout until stopped.
// - Store rows past the end row are clocked and discarded, never sent.
// - Normal mode when exposure exceeds readout time, else short mode; the sequencer also picks normal when the two are equal.
// - Short mode exposure is a plain wait, not overlapped with readout.
// - Short mode uses the same steps plus an image flush before exposure.
// - Short mode flushes 1026 image rows after readout, then exposes.

`ifndef CCD_SEQ_PARAMS_SVH
`define CCD_SEQ_PARAMS_SVH

// --------------------------------------------------------------------------
// clock and timing
// --------------------------------------------------------------------------
`define CLK_MHZ 10
`define XFER_MAX_MS 60
`define READ_MAX_MS 6500
`define XFER_MAX_CYC (`XFER_MAX_MS * 1000 * `CLK_MHZ)
`define READ_MAX_CYC (`READ_MAX_MS * 1000 * `CLK_MHZ)

// --------------------------------------------------------------------------
// step counts
// --------------------------------------------------------------------------
`define CLEAR_ROWS 1026
`define XFER_ROWS 1026
`define FLUSH_ROWS 1026
`define POS_EXTRA_ROWS 2
`define QUAD_PIX (256 + 4)
`define PAIR_PIX (512 + 8)
`define CLEAR_PASSES 1

// --------------------------------------------------------------------------
// default rates and widths
// --------------------------------------------------------------------------
`define ROW_DIV 4
`define PIX_DIV 4
`define SAMPLE_DELAY 3
`define PIX_W 12

`endif

// *** hdl/ccd_seq_pkg.sv ***
// Types shared by the exposure clock sequencer and its rate divider.
// Assumes ccd_seq_params.svh is on the include path.
`include "ccd_seq_params.svh"

package ccd_seq_pkg;

    // ----------------------------------------------------------------------
    // readout modes of the output registers
    // ----------------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_FULL = 2'h0,
        MODE_DIAG = 2'h1,
        MODE_TWO_NODE_READOUT_FIRST_PAIR = 2'h2,
        MODE_TWO_NODE_READOUT_SECOND_PAIR = 2'h3
    } readout_mode_t;

    // ----------------------------------------------------------------------
    // sequencer steps, one-hot
    // ----------------------------------------------------------------------
    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_CLEAR_ROWS = 10'h002,
        ST_CLEAR_SHIFT = 10'h004,
        ST_EXPOSE = 10'h008,
        ST_XFER = 10'h010,
        ST_POSITION = 10'h020,
        ST_DISCARD = 10'h040,
        ST_READ_ROW = 10'h080,
        ST_READ_PIX = 10'h100,
        ST_FLUSH = 10'h200
    } seq_state_t;

    typedef struct packed {
        logic [15:0] cnt;
        logic tick;
    } divider_reg_t;

    typedef struct packed {
        seq_state_t state;
        logic [10:0] rowCnt;
        logic [9:0] pixCnt;
        logic [3:0] passCnt;
        logic [27:0] expCnt;
        logic [26:0] stepCyc;
        logic shortMode;
        logic stopReq;
        logic [9:0] startRow;
        logic [9:0] endRow;
        readout_mode_t mode;
        logic [7:0] ovc;
        logic [27:0] expCyc;
        logic [`PIX_W-1:0] adcMeta;
        logic [`PIX_W-1:0] adcSync;
        logic [`SAMPLE_DELAY-1:0] tagPipe;
        logic [`SAMPLE_DELAY-1:0] ovPipe;
        logic imageRowClk;
        logic storeRowClk;
        logic serialClk;
        logic convStart;
        logic [`PIX_W-1:0] pixelData;
        logic pixelValid;
        logic pixelOverclock;
        logic frameStart;
        logic busy;
        logic timingFault;
    } seq_reg_t;

endpackage : ccd_seq_pkg

// *** hdl/rate_divider.sv ***
// One-cycle enable pulse every DIV clocks while run is high.
// Assumes run comes from logic on the same clock.
`timescale 1ns/1ps

module rate_divider #(
    parameter int DIV = 4
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic run,
    output logic tick
);
    import ccd_seq_pkg::*;

    localparam logic [15:0] LAST = 16'(DIV - 1);

    divider_reg_t q;
    divider_reg_t n;

    // restarting on run keeps the first pulse a full period after start
    always_comb begin
        n = q;
        n.tick = 1'b0;
        if (!run) begin
            n.cnt = 16'h0000;
        end else if (q.cnt == LAST) begin
            n.cnt = 16'h0000;
            n.tick = 1'b1;
        end else begin
            n.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign tick = q.tick;

endmodule : rate_divider
